// >>> core/lane_regs_pkg.sv
package lane_regs_pkg;
    localparam int unsigned NUM_LANES = 8;
    localparam int unsigned TRIM_W = 12;
    localparam int unsigned NUM_TRIMS = 3;
    // Offsets are not all word aligned: they are register indices, byte address is index * 4
    localparam logic [11:0] IDX_LANE_FLAGS = 12'h2c4;
    localparam logic [11:0] IDX_TRIM0 = 12'h330;
    localparam logic [11:0] IDX_TRIM1 = 12'h332;
    localparam logic [11:0] IDX_TRIM2A = 12'h334;
    localparam logic [11:0] IDX_CAL_CTRL = 12'h340;
    localparam logic [11:0] IDX_STATUS = 12'h341;
    localparam logic [7:0] LANE_FLAGS_RST = 8'hff;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam int unsigned OFFSET_CAL_EN_BIT = 0;
    localparam int unsigned BG_CAL_EN_BIT = 1;
    localparam int unsigned BG_OFFSET_CAL_EN_BIT = 2;
    localparam int unsigned SUM_CLR_BIT = 0;
    localparam int unsigned MASK_BIT = 1;
    localparam int unsigned ST_SUM_BIT = 0;
    localparam int unsigned ST_ALARM_BIT = 1;
    localparam int unsigned ST_FGDONE_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [4:0] CTRL_RST = 5'h02;
endpackage : lane_regs_pkg

// >>> core/lane_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
module lane_flag_bank (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, low
    input wire logic soft_reset, // Synchronous soft reset pulse
    input wire logic [7:0] lane_error, // Synchronised lane overflow/underflow levels
    input wire logic [7:0] clear_mask, // Write-one-to-clear bits, one cycle
    input wire logic clear_all, // Clear every bit, one cycle
    output logic [7:0] flags // Sticky lane flags
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_lane
            always_comb begin
                if (soft_reset) begin
                    flags_next[gi] = lane_regs_pkg::LANE_FLAGS_RST[gi];
                end else if (lane_error[gi]) begin
                    flags_next[gi] = 1'b1;
                end else if (clear_mask[gi] || clear_all) begin
                    flags_next[gi] = 1'b0;
                end else begin
                    flags_next[gi] = flags_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= lane_regs_pkg::LANE_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule : lane_flag_bank
`default_nettype wire

// >>> core/offset_trim_unit.sv
`timescale 1ns/1ns
`default_nettype none
module offset_trim_unit (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, low
    input wire logic [11:0] sample_in, // Raw core sample
    input wire logic sample_valid, // Sample qualifier
    input wire logic apply_en, // Trim applies to this sample
    input wire logic [11:0] trim, // Unsigned trim value
    output logic [12:0] sample_out, // Trimmed sample, carry in top bit
    output logic sample_out_valid // Output qualifier
);
    logic [12:0] out_reg;
    logic [12:0] out_next;
    logic vld_reg;
    logic vld_next;

    always_comb begin
        vld_next = sample_valid;
        out_next = out_reg;
        if (sample_valid) begin
            out_next = apply_en ? ({1'b0, sample_in} + {1'b0, trim}) : {1'b0, sample_in};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_reg <= 13'h0000;
            vld_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            vld_reg <= vld_next;
        end
    end

    assign sample_out = out_reg;
    assign sample_out_valid = vld_reg;
endmodule : offset_trim_unit
`default_nettype wire

// >>> core/lane_fifo_alarm_offset_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - One 8-bit flag register, bit i set on lane i FIFO overflow or underflow.
// - Writing one to a flag bit clears it; zero leaves it.
// - A flag written one to clear stays set while its lane condition persists; the lane error wins over the clear.
// - Writing one to the summary alarm clears all eight lane flags.
// - Lane flag register resets to all ones.
// - Each trim register holds a 12-bit unsigned offset added to its core.
// - Trim registers take power-up defaults from fuse storage.
// - Spare cores still get offsets calibrated in the foreground step when offset and background cal are on and background offset cal is off.
// - Core 1 has its own trim register applied only to core 1.
// - Core 2 input-A trim applies only while core 2 samples input A.
// - Masked summary FIFO alarm does not reach the combined alarm.
// - Power-on or soft reset sets every alarm bit to one; power-on clears combined_alarm until the first clock.
module lane_fifo_alarm_offset_regs (
    input wire logic hclk, // Bus clock, 20 MHz
    input wire logic hresetn, // Async reset, low
    input wire logic hsel, // Slave select
    input wire logic [13:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic soft_reset, // Soft reset pulse, same clock
    input wire logic [7:0] lane_fifo_error, // Lane FIFO overflow/underflow, async
    input wire logic fuse_valid, // Fuse contents ready, async level
    input wire logic [35:0] fuse_trim, // Fuse defaults, three 12-bit fields
    input wire logic cal_offset_active, // Offset calibration running, async
    input wire logic foreground_cal_done, // Foreground calibration done, async
    input wire logic cal_spare_step, // Foreground offset step on spare cores, async
    input wire logic [35:0] core_sample, // Core 0..2 samples, 12 bits each
    input wire logic [2:0] core_sample_valid, // Sample qualifiers
    input wire logic core2_on_input_a, // Core 2 sampling analog_input_a
    output logic [38:0] core_trimmed, // Trimmed samples, 13 bits each
    output logic [2:0] core_trimmed_valid, // Trimmed qualifiers
    output logic summary_fifo_error, // Any lane flag set
    output logic combined_alarm, // Combined alarm contribution
    output logic offset_cal_enable, // Calibration control out
    output logic background_cal_enable, // Calibration control out
    output logic background_offset_cal_enable, // Calibration control out
    output logic spare_offset_cal // Spare core offset calibration request
);
    logic [7:0] err_s1_reg, err_s2_reg;
    logic [3:0] st_s1_reg, st_s2_reg;
    logic fuse_s1_reg, fuse_s2_reg;
    logic [35:0] fuse_trim_s1_reg;
    logic [35:0] fuse_trim_s2_reg;
    logic [7:0] lane_flags;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_s1_reg <= 8'h00;
            err_s2_reg <= 8'h00;
            st_s1_reg <= 4'h0;
            st_s2_reg <= 4'h0;
            fuse_s1_reg <= 1'b0;
            fuse_s2_reg <= 1'b0;
            fuse_trim_s1_reg <= 36'h0;
            fuse_trim_s2_reg <= 36'h0;
        end else begin
            err_s1_reg <= lane_fifo_error;
            err_s2_reg <= err_s1_reg;
            st_s1_reg <= {cal_spare_step, foreground_cal_done, cal_offset_active, 1'b0};
            st_s2_reg <= st_s1_reg;
            fuse_s1_reg <= fuse_valid;
            fuse_s2_reg <= fuse_s1_reg;
            fuse_trim_s1_reg <= fuse_trim;
            fuse_trim_s2_reg <= fuse_trim_s1_reg;
        end
    end

    logic cal_busy, cal_done_sync, spare_step;
    assign cal_busy = st_s2_reg[1];
    assign cal_done_sync = st_s2_reg[2];
    assign spare_step = st_s2_reg[3];

    // Bus address phase capture
    logic ph_valid_reg, ph_valid_next;
    logic ph_write_reg, ph_write_next;
    logic [11:0] ph_idx_reg, ph_idx_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic take;

    assign take = hsel && hready && (htrans == lane_regs_pkg::HTRANS_NONSEQ)
                  && (hsize == lane_regs_pkg::HSIZE_WORD);

    // Registers
    logic [15:0] trim_reg [3];
    logic [15:0] trim_next [3];
    logic [4:0] ctrl_reg, ctrl_next;
    logic fuse_done_reg, fuse_done_next;
    logic [7:0] clear_mask;
    logic clear_all;
    logic wr_now;

    assign wr_now = ph_valid_reg && ph_write_reg;

    always_comb begin
        ph_valid_next = take;
        ph_write_next = hwrite;
        ph_idx_next = haddr[13:2];
        ready_next = 1'b1;
        clear_mask = 8'h00;
        clear_all = 1'b0;
        ctrl_next = ctrl_reg;
        fuse_done_next = fuse_done_reg;
        for (int k = 0; k < 3; k++) begin
            trim_next[k] = trim_reg[k];
        end
        if (!fuse_done_reg && fuse_s2_reg) begin
            fuse_done_next = 1'b1;
            for (int k = 0; k < 3; k++) begin
                trim_next[k] = {4'h0, fuse_trim_s2_reg[k*12 +: 12]};
            end
        end
        if (wr_now) begin
            case (ph_idx_reg)
                lane_regs_pkg::IDX_LANE_FLAGS: clear_mask = hwdata[7:0];
                lane_regs_pkg::IDX_TRIM0: trim_next[0] = hwdata[15:0];
                lane_regs_pkg::IDX_TRIM1: trim_next[1] = hwdata[15:0];
                lane_regs_pkg::IDX_TRIM2A: trim_next[2] = hwdata[15:0];
                lane_regs_pkg::IDX_CAL_CTRL: begin
                    ctrl_next = hwdata[4:0];
                    clear_all = hwdata[lane_regs_pkg::SUM_CLR_BIT + 3];
                end
                default: ;
            endcase
        end
        if (soft_reset) begin
            ctrl_next = lane_regs_pkg::CTRL_RST;
        end
    end

    // Control layout: [2:0] cal enables, [3] summary clear (self clearing), [4] summary mask
    logic sum_mask;
    assign sum_mask = ctrl_reg[lane_regs_pkg::MASK_BIT + 3];

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (take && !hwrite) begin
            case (haddr[13:2])
                lane_regs_pkg::IDX_LANE_FLAGS: rdata_next = {24'h000000, lane_flags};
                lane_regs_pkg::IDX_TRIM0: rdata_next = {16'h0000, trim_reg[0]};
                lane_regs_pkg::IDX_TRIM1: rdata_next = {16'h0000, trim_reg[1]};
                lane_regs_pkg::IDX_TRIM2A: rdata_next = {16'h0000, trim_reg[2]};
                lane_regs_pkg::IDX_CAL_CTRL: rdata_next = {27'h0000000, ctrl_reg[4], 1'b0, ctrl_reg[2:0]};
                lane_regs_pkg::IDX_STATUS: rdata_next = {28'h0000000, cal_busy, cal_done_sync,
                                                         combined_alarm, summary_fifo_error};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_idx_reg <= 12'h000;
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b1;
            ctrl_reg <= lane_regs_pkg::CTRL_RST;
            fuse_done_reg <= 1'b0;
            for (int k = 0; k < 3; k++) begin
                trim_reg[k] <= lane_regs_pkg::TRIM_RST;
            end
        end else begin
            ph_valid_reg <= ph_valid_next;
            ph_write_reg <= ph_write_next;
            ph_idx_reg <= ph_idx_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            ctrl_reg <= ctrl_next;
            fuse_done_reg <= fuse_done_next;
            for (int k = 0; k < 3; k++) begin
                trim_reg[k] <= trim_next[k];
            end
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;

    lane_flag_bank u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .soft_reset(soft_reset),
        .lane_error(err_s2_reg),
        .clear_mask(clear_mask),
        .clear_all(clear_all),
        .flags(lane_flags)
    );

    // Alarm outputs and calibration controls
    logic sum_reg, sum_next, comb_reg, comb_next, spare_reg, spare_next;

    always_comb begin
        sum_next = |lane_flags;
        comb_next = (|lane_flags) && !sum_mask;
        // Offset and background cal on with offset tracking off still trims spare cores in the foreground step
        spare_next = spare_step && ctrl_reg[lane_regs_pkg::OFFSET_CAL_EN_BIT]
                     && ctrl_reg[lane_regs_pkg::BG_CAL_EN_BIT]
                     && !ctrl_reg[lane_regs_pkg::BG_OFFSET_CAL_EN_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum_reg <= 1'b1;
            comb_reg <= 1'b0;
            spare_reg <= 1'b0;
        end else begin
            sum_reg <= sum_next;
            comb_reg <= comb_next;
            spare_reg <= spare_next;
        end
    end

    assign summary_fifo_error = sum_reg;
    assign combined_alarm = comb_reg;
    assign spare_offset_cal = spare_reg;
    assign offset_cal_enable = ctrl_reg[lane_regs_pkg::OFFSET_CAL_EN_BIT];
    assign background_cal_enable = ctrl_reg[lane_regs_pkg::BG_CAL_EN_BIT];
    assign background_offset_cal_enable = ctrl_reg[lane_regs_pkg::BG_OFFSET_CAL_EN_BIT];

    // Trim datapaths; core 2 trim only while on analog_input_a
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_core
            offset_trim_unit u_trim (
                .hclk(hclk),
                .hresetn(hresetn),
                .sample_in(core_sample[gc*12 +: 12]),
                .sample_valid(core_sample_valid[gc]),
                .apply_en((gc == 2) ? core2_on_input_a : 1'b1),
                .trim(trim_reg[gc][11:0]),
                .sample_out(core_trimmed[gc*13 +: 13]),
                .sample_out_valid(core_trimmed_valid[gc])
            );
        end
    endgenerate
endmodule : lane_fifo_alarm_offset_regs
`default_nettype wire

// >>> test/lane_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module lane_regs_sva (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic hsel, // Select
    input wire logic [13:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Data
    input wire logic hreadyout, // Ready
    input wire logic hresp, // Response
    input wire logic soft_reset, // Soft reset
    input wire logic [35:0] core_sample, // Samples
    input wire logic [2:0] core_sample_valid, // Valids
    input wire logic core2_on_input_a, // Input A
    input wire logic [38:0] core_trimmed, // Trimmed
    input wire logic [2:0] core_trimmed_valid, // Valids
    input wire logic summary_fifo_error, // Summary
    input wire logic combined_alarm, // Combined
    input wire logic offset_cal_enable, // Control
    input wire logic background_cal_enable, // Control
    input wire logic background_offset_cal_enable, // Control
    input wire logic spare_offset_cal // Spare
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic ctrl_wr;
    assign ctrl_wr = hsel && htrans == lane_regs_pkg::HTRANS_NONSEQ && hwrite
                     && haddr[13:2] == lane_regs_pkg::IDX_CAL_CTRL;
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("Bus answer not ready or not okay");
    property p_comb; combined_alarm |-> summary_fifo_error; endproperty
    a_comb: assert property (p_comb) else $error("Combined alarm without summary");
    property p_mask; ctrl_wr ##1 (hwdata[4] && !soft_reset) ##1 !soft_reset |-> ##1 !combined_alarm; endproperty
    a_mask: assert property (p_mask) else $error("Masked summary still reaches combined");
    property p_ctrl;
        ctrl_wr ##1 !soft_reset ##1 !soft_reset |->
            ##1 {background_offset_cal_enable, background_cal_enable, offset_cal_enable} == $past(hwdata[2:0], 2);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("Calibration controls differ from write");
    property p_spare;
        spare_offset_cal |-> $past(offset_cal_enable) && $past(background_cal_enable)
            && !$past(background_offset_cal_enable);
    endproperty
    a_spare: assert property (p_spare) else $error("Spare request in wrong mode");
    property p_soft; soft_reset |-> ##2 (summary_fifo_error && combined_alarm); endproperty
    a_soft: assert property (p_soft) else $error("Alarms not set after soft reset");
    property p_valid; 1'b1 |=> core_trimmed_valid == $past(core_sample_valid); endproperty
    a_valid: assert property (p_valid) else $error("Trimmed valid latency wrong");
    property p_core2;
        core_sample_valid[2] && !core2_on_input_a |=> core_trimmed[38:26] == {1'b0, $past(core_sample[35:24])};
    endproperty
    a_core2: assert property (p_core2) else $error("Core 2 trim applied off input A");
    cover property (ctrl_wr ##1 hwdata[4]);
    cover property (spare_offset_cal);
    cover property (soft_reset ##2 summary_fifo_error);
endmodule : lane_regs_sva
bind lane_fifo_alarm_offset_regs lane_regs_sva i_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .soft_reset(soft_reset), .core_sample(core_sample),
    .core_sample_valid(core_sample_valid), .core2_on_input_a(core2_on_input_a), .core_trimmed(core_trimmed),
    .core_trimmed_valid(core_trimmed_valid), .summary_fifo_error(summary_fifo_error),
    .combined_alarm(combined_alarm), .offset_cal_enable(offset_cal_enable),
    .background_cal_enable(background_cal_enable), .background_offset_cal_enable(background_offset_cal_enable),
    .spare_offset_cal(spare_offset_cal)
);
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [13:0] A_FLG = {lane_regs_pkg::IDX_LANE_FLAGS, 2'b00};
    localparam logic [13:0] A_T0 = {lane_regs_pkg::IDX_TRIM0, 2'b00};
    localparam logic [13:0] A_T1 = {lane_regs_pkg::IDX_TRIM1, 2'b00};
    localparam logic [13:0] A_T2 = {lane_regs_pkg::IDX_TRIM2A, 2'b00};
    localparam logic [13:0] A_CTL = {lane_regs_pkg::IDX_CAL_CTRL, 2'b00};
    localparam logic [13:0] A_ST = {lane_regs_pkg::IDX_STATUS, 2'b00};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_reset = 1'b0, fuse_valid = 1'b0;
    logic cal_offset_active = 1'b0, foreground_cal_done = 1'b0, cal_spare_step = 1'b0, core2_on_input_a = 1'b0;
    logic [13:0] haddr = 14'h0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, core_sample_valid = 3'h0, core_trimmed_valid;
    logic [31:0] hwdata = 32'h0, hrdata, rd_q;
    logic [7:0] lane_fifo_error = 8'h00;
    logic [35:0] fuse_trim = 36'h0, core_sample = 36'h0;
    logic [38:0] core_trimmed;
    logic hreadyout, hresp, summary_fifo_error, combined_alarm, offset_cal_enable, background_cal_enable;
    logic background_offset_cal_enable, spare_offset_cal, rdy_q;
    int miscompares = 0, compares = 0;
    lane_fifo_alarm_offset_regs i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .soft_reset(soft_reset), .lane_fifo_error(lane_fifo_error), .fuse_valid(fuse_valid), .fuse_trim(fuse_trim),
        .cal_offset_active(cal_offset_active), .foreground_cal_done(foreground_cal_done),
        .cal_spare_step(cal_spare_step), .core_sample(core_sample), .core_sample_valid(core_sample_valid),
        .core2_on_input_a(core2_on_input_a), .core_trimmed(core_trimmed), .core_trimmed_valid(core_trimmed_valid),
        .summary_fifo_error(summary_fifo_error), .combined_alarm(combined_alarm),
        .offset_cal_enable(offset_cal_enable), .background_cal_enable(background_cal_enable),
        .background_offset_cal_enable(background_offset_cal_enable), .spare_offset_cal(spare_offset_cal)
    );
    always #25 hclk = ~hclk;
    // Bus answers as they stood at the rising edge
    always @(posedge hclk) begin
        rd_q <= hrdata;
        rdy_q <= hreadyout;
    end
    task automatic stop_test;
        $display("miscompares=%0d compares=%0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tick
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            tick(1);
            i++;
        end while (rdy_q !== 1'b1 && i < 20);
        if (rdy_q !== 1'b1) begin
            chk({31'h0, rdy_q}, 32'h1);
            stop_test();
        end
    endtask : wait_rdy
    // One single word transfer; a read compares against d
    task automatic acc(input logic wr, input logic [13:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= lane_regs_pkg::HTRANS_NONSEQ;
        hsize <= lane_regs_pkg::HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        wait_rdy();
        if (!wr) begin
            chk(rd_q, d);
        end
    endtask : acc
    task automatic t_reset_fuse;
        acc(1'b0, A_FLG, 32'hff);
        acc(1'b0, A_CTL, 32'h02);
        acc(1'b0, A_ST, 32'h03);
        acc(1'b0, A_T0, 32'h0);
        acc(1'b0, 14'h0004, 32'h0);
        fuse_trim <= 36'h333222111;
        fuse_valid <= 1'b1;
        tick(6);
        acc(1'b0, A_T0, 32'h111);
        acc(1'b0, A_T1, 32'h222);
        acc(1'b0, A_T2, 32'h333);
    endtask : t_reset_fuse
    task automatic t_trim;
        acc(1'b1, A_T0, 32'h0abc);
        acc(1'b1, A_T1, 32'h0123);
        acc(1'b1, A_T2, 32'h0fff);
        acc(1'b0, A_T0, 32'h0abc);
        acc(1'b0, A_T1, 32'h0123);
        core_sample <= {3{12'h100}};
        core_sample_valid <= 3'h7;
        core2_on_input_a <= 1'b1;
        tick(1);
        chk({6'h0, core_trimmed[25:0]}, {6'h0, 13'h0223, 13'h0bbc});
        chk({19'h0, core_trimmed[38:26]}, 32'h10ff);
        chk({29'h0, core_trimmed_valid}, 32'h7);
        core2_on_input_a <= 1'b0;
        tick(1);
        chk({19'h0, core_trimmed[38:26]}, 32'h0100);
        core_sample_valid <= 3'h0;
    endtask : t_trim
    task automatic t_flags;
        acc(1'b1, A_FLG, 32'hff);
        acc(1'b0, A_FLG, 32'h00);
        lane_fifo_error <= 8'h28;
        tick(2);
        lane_fifo_error <= 8'h01;
        tick(5);
        acc(1'b0, A_FLG, 32'h29);
        acc(1'b1, A_FLG, 32'h09);
        acc(1'b0, A_FLG, 32'h21);
        lane_fifo_error <= 8'h00;
        tick(4);
        acc(1'b1, A_CTL, 32'h0a);
        acc(1'b0, A_FLG, 32'h00);
        acc(1'b0, A_CTL, 32'h02);
        acc(1'b0, A_ST, 32'h00);
    endtask : t_flags
    task automatic t_mask;
        lane_fifo_error <= 8'h80;
        tick(5);
        lane_fifo_error <= 8'h00;
        acc(1'b0, A_ST, 32'h03);
        acc(1'b1, A_CTL, 32'h12);
        tick(2);
        acc(1'b0, A_ST, 32'h01);
        chk({30'h0, combined_alarm, summary_fifo_error}, 32'h1);
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
        tick(2);
        acc(1'b0, A_FLG, 32'hff);
        acc(1'b0, A_CTL, 32'h02);
        acc(1'b0, A_ST, 32'h03);
    endtask : t_mask
    task automatic t_cal;
        cal_spare_step <= 1'b1;
        cal_offset_active <= 1'b1;
        acc(1'b1, A_CTL, 32'h03);
        tick(4);
        chk({31'h0, spare_offset_cal}, 32'h1);
        chk({29'h0, background_offset_cal_enable, background_cal_enable, offset_cal_enable}, 32'h3);
        acc(1'b0, A_ST, 32'h0b);
        acc(1'b1, A_CTL, 32'h07);
        tick(4);
        chk({31'h0, spare_offset_cal}, 32'h0);
        cal_offset_active <= 1'b0;
        foreground_cal_done <= 1'b1;
        tick(4);
        acc(1'b0, A_ST, 32'h07);
        acc(1'b1, A_CTL, 32'h02);
        acc(1'b1, A_T0, 32'h0005);
        acc(1'b0, A_T0, 32'h0005);
    endtask : t_cal
    initial begin
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        t_reset_fuse();
        t_trim();
        t_flags();
        t_mask();
        t_cal();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
